// File: verilog/timer_pkg.sv
package timer_pkg;
   // ==========================================================
   // register placement
   localparam logic [3:0] BANK_TIMERS = 4'hd;
   localparam logic [3:0] OFF_CTRL8 = 4'h0;
   localparam logic [3:0] OFF_COMMON_CTRL = 4'h1;
   localparam logic [3:0] OFF_CTRL16 = 4'h2;
   localparam logic [3:0] OFF_RELOAD8 = 4'h4;
   localparam logic [3:0] OFF_RELOAD16_LO = 4'h6;
   localparam logic [3:0] OFF_RELOAD16_HI = 4'h7;
   localparam logic [3:0] OFF_CAP16_LO = 4'h8;
   localparam logic [3:0] OFF_CAP16_HI = 4'h9;
   localparam logic [3:0] OFF_CAP8_LO = 4'ha;
   localparam logic [3:0] OFF_CAP8_HI = 4'hb;
   // ==========================================================
   // timer8_control fields (timer16 control reuses enable, single, rate)
   localparam int B_ENABLE = 7;
   localparam int B_SINGLE = 6;
   localparam int B_TIMEOUT = 5;
   localparam int B_RATE_HI = 4;
   localparam int B_RATE_LO = 3;
   localparam int B_CAP_MASK = 2;
   localparam int B_TO_MASK = 1;
   localparam int B_PIN_A_SEL = 0;
   // ==========================================================
   // timer_common_control fields
   localparam int B_MODE = 7;
   localparam int B_PIN_B_SEL = 6;
   localparam int B_COMBINE_HI = 5;
   localparam int B_COMBINE_LO = 4;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int RATE_W = 2;
   localparam int DIV_W = 3;
   // ==========================================================
   typedef enum logic [1:0] {
      COMB_AND,
      COMB_OR,
      COMB_NOR,
      COMB_NAND
   } combine_t;
   typedef enum logic [1:0] {
      EDGE_FALL,
      EDGE_RISE,
      EDGE_BOTH,
      EDGE_NONE
   } edge_sel_t;
endpackage

// File: verilog/counter_if.sv
`timescale 1ns/1ps
interface counter_if #(parameter int W = 8);
   logic start;
   logic stop_req;
   logic single;
   logic tick;
   logic [W-1:0] reload;
   logic [W-1:0] count;
   logic running;
   logic tc;
   logic out;
   modport ctl (output start, stop_req, single, tick, reload,
                input count, running, tc, out);
   modport cnt (input start, stop_req, single, tick, reload,
                output count, running, tc, out);
endinterface

// File: verilog/down_counter.sv
`timescale 1ns/1ps
module down_counter
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // control and state
   counter_if.cnt c
);
   logic at_end;
   assign at_end = c.running && c.tick && (c.count == '0);

   // ==========================================================
   // count, reload and stop
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         c.count <= '0;
         c.running <= 1'b0;
      end
      else if (c.start)
      begin
         c.count <= c.reload;
         c.running <= 1'b1;
      end
      else if (c.stop_req)
         c.running <= 1'b0;
      else if (at_end)
      begin
         c.count <= c.reload;
         c.running <= !c.single;
      end
      else if (c.running && c.tick)
         c.count <= c.count - 1'b1;
   end

   // ==========================================================
   // terminal count pulse and output toggle
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         c.tc <= 1'b0;
         c.out <= 1'b0;
      end
      else
      begin
         c.tc <= at_end && !c.start && !c.stop_req;
         if (at_end && !c.start && !c.stop_req)
            c.out <= !c.out;
      end
   end
endmodule // down_counter

// File: verilog/dual_counter_timer.sv
// How it works
// - single bit 0: eight_bit_counter reloads at terminal count, keeps counting
// - single bit 1: eight_bit_counter stops at terminal count
// - timeout flag set at terminal count, cleared only by writing 1
// - writing 1 to the enable field starts eight_bit_counter
// - first count tick after enable may come early, any time
// - timeout mask on requests interrupt on timeout; mask resets to 0
// - capture mask on requests interrupt on every 8-bit capture
// - control bit 0 picks port value or eight_bit_counter output on pin a
// - bit 7 picks transmit/demod; bit 6 picks pin b source or input
// - transmit: bits 5-4 combine outputs as AND, OR, NOR, NAND
// - demod: bits 5-4 pick falling, rising or both edges; 11 none
// - high capture holds counts taken while input was high
// - low capture holds counts taken while input was low
// - sixteen_bit_counter capture split into high and low byte
// - all timer registers sit in expanded_register_bank D
`timescale 1ns/1ps
module dual_counter_timer
   import timer_pkg::*;
#(
   parameter int CNT8_W = 8,
   parameter int CNT16_W = 16
)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // register port
   input wire logic [3:0] i_reg_bank,
   input wire logic [3:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // port values and demodulator inputs
   input wire logic i_port_a_value,
   input wire logic i_port_b_value,
   input wire logic i_demod_in_a,
   input wire logic i_demod_in_b,
   // pins and requests
   output logic o_pin_a,
   output logic o_pin_b,
   output logic o_irq_timeout,
   output logic o_irq_capture
);
   import timer_pkg::*;

   counter_if #(.W(CNT8_W)) c8 ();
   counter_if #(.W(CNT16_W)) c16 ();

   // ==========================================================
   // decode
   logic in_bank;
   logic wr_ctrl8;
   logic wr_common;
   logic wr_ctrl16;
   assign in_bank = (i_reg_bank == BANK_TIMERS);
   assign wr_ctrl8 = i_reg_wr && in_bank && (i_reg_addr == OFF_CTRL8);
   assign wr_common = i_reg_wr && in_bank
                      && (i_reg_addr == OFF_COMMON_CTRL);
   assign wr_ctrl16 = i_reg_wr && in_bank
                      && (i_reg_addr == OFF_CTRL16);

   // ==========================================================
   // software registers
   logic single8_reg;
   logic [RATE_W-1:0] rate8_reg;
   logic cap_mask_reg;
   logic to_mask_reg;
   logic pin_a_sel_reg;
   logic demod_mode_reg;
   logic pin_b_sel_reg;
   logic [1:0] combine_reg;
   logic single16_reg;
   logic [RATE_W-1:0] rate16_reg;
   logic [CNT8_W-1:0] reload8_reg;
   logic [CNT16_W-1:0] reload16_reg;

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         single8_reg <= 1'b0;
         rate8_reg <= '0;
         cap_mask_reg <= 1'b0;
         to_mask_reg <= 1'b0;
         pin_a_sel_reg <= 1'b0;
      end
      else if (wr_ctrl8)
      begin
         single8_reg <= i_reg_wdata[B_SINGLE];
         rate8_reg <= i_reg_wdata[B_RATE_HI:B_RATE_LO];
         cap_mask_reg <= i_reg_wdata[B_CAP_MASK];
         to_mask_reg <= i_reg_wdata[B_TO_MASK];
         pin_a_sel_reg <= i_reg_wdata[B_PIN_A_SEL];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         demod_mode_reg <= 1'b0;
         pin_b_sel_reg <= 1'b0;
         combine_reg <= '0;
      end
      else if (wr_common)
      begin
         demod_mode_reg <= i_reg_wdata[B_MODE];
         pin_b_sel_reg <= i_reg_wdata[B_PIN_B_SEL];
         combine_reg <= i_reg_wdata[B_COMBINE_HI:B_COMBINE_LO];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         single16_reg <= 1'b0;
         rate16_reg <= '0;
      end
      else if (wr_ctrl16)
      begin
         single16_reg <= i_reg_wdata[B_SINGLE];
         rate16_reg <= i_reg_wdata[B_RATE_HI:B_RATE_LO];
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         reload8_reg <= '0;
         reload16_reg <= '0;
      end
      else if (i_reg_wr && in_bank)
      begin
         case (i_reg_addr)
            OFF_RELOAD8: reload8_reg <= i_reg_wdata[CNT8_W-1:0];
            OFF_RELOAD16_LO: reload16_reg[7:0] <= i_reg_wdata;
            OFF_RELOAD16_HI: reload16_reg[CNT16_W-1:8] <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // ==========================================================
   // rate divider
   // free running on purpose: enabling a timer does not realign it,
   // so the first tick can land anywhere inside a period
   logic [DIV_W-1:0] div_reg;
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
         div_reg <= '0;
      else
         div_reg <= div_reg + 1'b1;
   end

   function automatic logic rate_tick(input logic [RATE_W-1:0] sel,
                                      input logic [DIV_W-1:0] div);
      logic [DIV_W-1:0] mask;
      mask = DIV_W'((1 << sel) - 1);
      return ((div & mask) == mask);
   endfunction

   // ==========================================================
   // demodulator input, synchronised and edge detected
   logic dem_a_s1_reg;
   logic dem_a_s2_reg;
   logic dem_b_s1_reg;
   logic dem_b_s2_reg;
   logic dem_prev_reg;
   logic dem_sel;
   logic rise;
   logic fall;
   logic cap_high;
   logic cap_low;
   logic capture;

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         dem_a_s1_reg <= 1'b0;
         dem_a_s2_reg <= 1'b0;
         dem_b_s1_reg <= 1'b0;
         dem_b_s2_reg <= 1'b0;
         dem_prev_reg <= 1'b0;
      end
      else
      begin
         dem_a_s1_reg <= i_demod_in_a;
         dem_a_s2_reg <= dem_a_s1_reg;
         dem_b_s1_reg <= i_demod_in_b;
         dem_b_s2_reg <= dem_b_s1_reg;
         dem_prev_reg <= dem_sel;
      end
   end

   // switching the input source can itself look like an edge
   assign dem_sel = pin_b_sel_reg ? dem_b_s2_reg : dem_a_s2_reg;
   assign rise = dem_sel && !dem_prev_reg;
   assign fall = !dem_sel && dem_prev_reg;

   always_comb
   begin
      cap_high = 1'b0;
      cap_low = 1'b0;
      case (edge_sel_t'(combine_reg))
         EDGE_FALL: cap_high = fall;
         EDGE_RISE: cap_low = rise;
         EDGE_BOTH:
         begin
            cap_high = fall;
            cap_low = rise;
         end
         EDGE_NONE: ;
         default: ;
      endcase
   end
   assign capture = demod_mode_reg && (cap_high || cap_low);

   // ==========================================================
   // counters
   logic start8;
   logic start16;
   assign start8 = (wr_ctrl8 && i_reg_wdata[B_ENABLE])
                   || (capture && c8.running);
   assign start16 = (wr_ctrl16 && i_reg_wdata[B_ENABLE])
                    || (capture && c16.running);

   assign c8.start = start8;
   assign c8.stop_req = wr_ctrl8 && !i_reg_wdata[B_ENABLE];
   assign c8.single = single8_reg;
   assign c8.tick = rate_tick(rate8_reg, div_reg);
   assign c8.reload = reload8_reg;

   assign c16.start = start16;
   assign c16.stop_req = wr_ctrl16 && !i_reg_wdata[B_ENABLE];
   assign c16.single = single16_reg;
   assign c16.tick = rate_tick(rate16_reg, div_reg);
   assign c16.reload = reload16_reg;

   down_counter u_eight_bit_counter
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .c(c8)
   );

   down_counter u_sixteen_bit_counter
   (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .c(c16)
   );

   // ==========================================================
   // timeout flag: set beats the clearing write
   logic timeout_reg;
   logic timeout_clr;
   assign timeout_clr = wr_ctrl8 && i_reg_wdata[B_TIMEOUT];
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
         timeout_reg <= 1'b0;
      else if (c8.tc)
         timeout_reg <= 1'b1;
      else if (timeout_clr)
         timeout_reg <= 1'b0;
   end

   // ==========================================================
   // capture registers, hardware only
   logic [7:0] cap8_hi_reg;
   logic [7:0] cap8_lo_reg;
   logic [CNT16_W-1:0] cap16_reg;
   logic [CNT8_W-1:0] elapsed8;
   logic [CNT16_W-1:0] elapsed16;
   assign elapsed8 = c8.reload - c8.count;
   assign elapsed16 = c16.reload - c16.count;

   // software writes never reach these
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         cap8_hi_reg <= RESET_BYTE;
         cap8_lo_reg <= RESET_BYTE;
         cap16_reg <= '0;
      end
      else if (capture)
      begin
         if (cap_high)
            cap8_hi_reg <= 8'(elapsed8);
         if (cap_low)
            cap8_lo_reg <= 8'(elapsed8);
         cap16_reg <= elapsed16;
      end
   end

   // ==========================================================
   // pins
   logic out8;
   logic out16;
   logic combined;
   assign out8 = c8.out;
   assign out16 = c16.out;

   always_comb
   begin
      combined = 1'b0;
      case (combine_t'(combine_reg))
         COMB_AND: combined = out8 & out16;
         COMB_OR: combined = out8 | out16;
         COMB_NOR: combined = !(out8 | out16);
         COMB_NAND: combined = !(out8 & out16);
         default: combined = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_pin_a <= 1'b0;
         o_pin_b <= 1'b0;
      end
      else
      begin
         o_pin_a <= pin_a_sel_reg ? out8 : i_port_a_value;
         // in demod mode bit 6 steers the input, pin b stays a port
         if (!demod_mode_reg && pin_b_sel_reg)
            o_pin_b <= combined;
         else
            o_pin_b <= i_port_b_value;
      end
   end

   // ==========================================================
   // interrupt requests
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_irq_timeout <= 1'b0;
         o_irq_capture <= 1'b0;
      end
      else
      begin
         o_irq_timeout <= to_mask_reg && timeout_reg;
         o_irq_capture <= cap_mask_reg && capture;
      end
   end

   // ==========================================================
   // read back
   logic [7:0] rd_mux;
   always_comb
   begin
      rd_mux = RESET_BYTE;
      case (i_reg_addr)
         OFF_CTRL8:
         begin
            rd_mux[B_ENABLE] = c8.running;
            rd_mux[B_SINGLE] = single8_reg;
            rd_mux[B_TIMEOUT] = timeout_reg;
            rd_mux[B_RATE_HI:B_RATE_LO] = rate8_reg;
            rd_mux[B_CAP_MASK] = cap_mask_reg;
            rd_mux[B_TO_MASK] = to_mask_reg;
            rd_mux[B_PIN_A_SEL] = pin_a_sel_reg;
         end
         OFF_COMMON_CTRL:
         begin
            rd_mux[B_MODE] = demod_mode_reg;
            rd_mux[B_PIN_B_SEL] = pin_b_sel_reg;
            rd_mux[B_COMBINE_HI:B_COMBINE_LO] = combine_reg;
         end
         OFF_CTRL16:
         begin
            rd_mux[B_ENABLE] = c16.running;
            rd_mux[B_SINGLE] = single16_reg;
            rd_mux[B_RATE_HI:B_RATE_LO] = rate16_reg;
         end
         OFF_RELOAD8: rd_mux = 8'(reload8_reg);
         OFF_RELOAD16_LO: rd_mux = reload16_reg[7:0];
         OFF_RELOAD16_HI: rd_mux = reload16_reg[CNT16_W-1:8];
         OFF_CAP16_LO: rd_mux = cap16_reg[7:0];
         OFF_CAP16_HI: rd_mux = cap16_reg[CNT16_W-1:8];
         OFF_CAP8_LO: rd_mux = cap8_lo_reg;
         OFF_CAP8_HI: rd_mux = cap8_hi_reg;
         default: rd_mux = RESET_BYTE;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         o_reg_rdata <= RESET_BYTE;
         o_reg_rvalid <= 1'b0;
      end
      else
      begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd)
            o_reg_rdata <= in_bank ? rd_mux : RESET_BYTE;
      end
   end
endmodule // dual_counter_timer

// File: sim/demod_source.sv
`timescale 1ns/1ps
module demod_source
(
   // clock
   input wire logic i_clk_sys,
   // modulated inputs
   output logic o_in_a,
   output logic o_in_b
);
   // =====
   // unselected line keeps toggling so a wrong select shows up
   logic lvl = 1'b0;
   logic [3:0] cnt = 4'h0;
   always @(posedge i_clk_sys)
      cnt <= cnt + 4'h1;
   assign o_in_a = cnt[3];
   assign o_in_b = lvl;
   // high h, low l, high h, then rest low
   task automatic wave(input int h, input int l);
      @(posedge i_clk_sys);
      lvl <= 1'b1;
      repeat (h) @(posedge i_clk_sys);
      lvl <= 1'b0;
      repeat (l) @(posedge i_clk_sys);
      lvl <= 1'b1;
      repeat (h) @(posedge i_clk_sys);
      lvl <= 1'b0;
      repeat (16) @(posedge i_clk_sys);
   endtask
endmodule // demod_source

// File: sim/dual_counter_timer_assertions.sv
`timescale 1ns/1ps
module dual_counter_timer_checker
   import timer_pkg::*;
#(
   parameter int CNT8_W = 8,
   parameter int CNT16_W = 16
)
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   // register port
   input wire logic [3:0] i_reg_bank,
   input wire logic [3:0] i_reg_addr,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic o_reg_rvalid,
   // pins
   input wire logic i_port_a_value,
   input wire logic i_port_b_value,
   input wire logic i_demod_in_a,
   input wire logic i_demod_in_b,
   input wire logic o_pin_a,
   input wire logic o_pin_b,
   input wire logic o_irq_timeout,
   input wire logic o_irq_capture
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   // =====
   // shadow of control writes, input history
   logic [7:0] sh0;
   logic [7:0] sh1;
   logic [1:0] up;
   logic [7:0] hist;
   logic wr_d;
   logic sel_in;
   logic fl;
   logic ri;
   logic ok;
   assign wr_d = i_reg_wr && i_reg_bank == BANK_TIMERS;
   assign sel_in = sh1[B_PIN_B_SEL] ? i_demod_in_b : i_demod_in_a;
   assign fl = |(hist[7:1] & ~hist[6:0]);
   assign ri = |(~hist[7:1] & hist[6:0]);
   assign ok = up[1];
   always_ff @(posedge i_clk_sys or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         sh0 <= RESET_BYTE;
         sh1 <= RESET_BYTE;
         up <= 2'b00;
         hist <= 8'h00;
      end
      else
      begin
         up <= {up[0], 1'b1};
         hist <= {hist[6:0], sel_in};
         if (wr_d && i_reg_addr == OFF_CTRL8)
            sh0 <= i_reg_wdata;
         if (wr_d && i_reg_addr == OFF_COMMON_CTRL)
            sh1 <= i_reg_wdata;
      end
   end
   // =====
   // assertions
   a_rvalid_follows_rd: assert property (
      i_reg_rd |=> o_reg_rvalid) else $error("rvalid missing");
   a_rvalid_no_spurious: assert property (
      o_reg_rvalid |-> $past(i_reg_rd)) else $error("stray rvalid");
   a_other_bank_zero: assert property (
      i_reg_rd && i_reg_bank != BANK_TIMERS |=> o_reg_rdata == 8'h00)
      else $error("foreign bank read not zero");
   a_unmapped_read_zero: assert property (
      i_reg_rd && i_reg_bank == BANK_TIMERS && (i_reg_addr == 4'h3 ||
      i_reg_addr == 4'h5 || i_reg_addr > 4'hb) |=> o_reg_rdata == 8'h00)
      else $error("unmapped read not zero");
   a_pin_a_port: assert property (
      ok && !$past(sh0[B_PIN_A_SEL]) |-> o_pin_a == $past(i_port_a_value))
      else $error("pin a not port value");
   a_pin_b_port: assert property (
      ok && ($past(sh1[B_MODE]) || !$past(sh1[B_PIN_B_SEL]))
      |-> o_pin_b == $past(i_port_b_value)) else $error("pin b not port");
   a_timeout_irq_mask: assert property (
      o_irq_timeout |-> $past(sh0[B_TO_MASK]))
      else $error("timeout request while masked");
   a_capture_irq_mask: assert property (
      o_irq_capture |-> $past(sh0[B_CAP_MASK]) && $past(sh1[B_MODE]))
      else $error("capture request masked or in transmit");
   a_capture_edge_kind: assert property (
      o_irq_capture |-> ($past(sh1[5:4]) == 2'b00 && fl) ||
      ($past(sh1[5:4]) == 2'b01 && ri) ||
      ($past(sh1[5:4]) == 2'b10 && (fl || ri)))
      else $error("capture without matching edge");
endmodule // dual_counter_timer_checker

bind dual_counter_timer dual_counter_timer_checker #(
   .CNT8_W(CNT8_W), .CNT16_W(CNT16_W)
) i_chk (
   .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_reg_bank(i_reg_bank),
   .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
   .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
   .o_reg_rvalid(o_reg_rvalid), .i_port_a_value(i_port_a_value),
   .i_port_b_value(i_port_b_value), .i_demod_in_a(i_demod_in_a),
   .i_demod_in_b(i_demod_in_b), .o_pin_a(o_pin_a), .o_pin_b(o_pin_b),
   .o_irq_timeout(o_irq_timeout), .o_irq_capture(o_irq_capture)
);

// File: sim/dual_counter_timer_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
   $display("BAD %s exp %h got %h", nm, e, s); end end
module dual_counter_timer_tb;
   import timer_pkg::*;
   logic clk = 1'b0;
   logic rst_b;
   logic [3:0] bank;
   logic [3:0] addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] wd;
   logic [7:0] rdata;
   logic rvalid;
   logic port_a;
   logic port_b;
   logic dem_a;
   logic dem_b;
   logic pin_a;
   logic pin_b;
   logic irq_to;
   logic irq_cap;
   logic [7:0] d;
   logic [7:0] hi;
   logic [7:0] lo;
   logic [7:0] c16l;
   logic [7:0] c16h;
   int n_fail = 0;
   int n_tests = 0;
   int n_cap = 0;
   int n;
   int i;
   int caps[4] = '{2, 2, 4, 0};
   always #20 clk = ~clk;
   always @(posedge clk)
      if (irq_cap === 1'b1)
         n_cap++;
   dual_counter_timer i_dut (
      .i_clk_sys(clk), .i_rst_b(rst_b), .i_reg_bank(bank),
      .i_reg_addr(addr), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
      .i_reg_wdata(wd), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
      .i_port_a_value(port_a), .i_port_b_value(port_b),
      .i_demod_in_a(dem_a), .i_demod_in_b(dem_b), .o_pin_a(pin_a),
      .o_pin_b(pin_b), .o_irq_timeout(irq_to), .o_irq_capture(irq_cap));
   demod_source i_src (.i_clk_sys(clk), .o_in_a(dem_a), .o_in_b(dem_b));
   // =====
   // register access
   task automatic wr_reg(input logic [3:0] b, input logic [3:0] a,
                         input logic [7:0] v);
      @(posedge clk);
      bank <= b;
      addr <= a;
      wd <= v;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [3:0] b, input logic [3:0] a,
                         output logic [7:0] v);
      @(posedge clk);
      bank <= b;
      addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(posedge clk);
      `CHK("rvalid", 1'b1, rvalid)
      v = rdata;
   endtask
   // cycles until pin a changes, lim if it never does
   task automatic wait_tog(input int lim, output int k);
      logic p;
      p = pin_a;
      k = 0;
      while (k < lim && pin_a === p)
      begin
         @(posedge clk);
         k++;
      end
   endtask
   task automatic summarize;
      $display("checks %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // =====
   // tests
   initial
   begin
      repeat (20000) @(posedge clk);
      n_fail++;
      summarize();
   end
   initial
   begin
      rst_b = 1'b0;
      bank = 4'h0;
      addr = 4'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      wd = 8'h00;
      port_a = 1'b0;
      port_b = 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      for (i = 0; i < 16; i++)
      begin
         rd_reg(BANK_TIMERS, i[3:0], d);
         `CHK("reset", RESET_BYTE, d)
      end
      wr_reg(BANK_TIMERS, OFF_RELOAD8, 8'h5a);
      wr_reg(4'he, OFF_RELOAD8, 8'hff);
      rd_reg(BANK_TIMERS, OFF_RELOAD8, d);
      `CHK("reload8", 8'h5a, d)
      rd_reg(4'he, OFF_RELOAD8, d);
      `CHK("bank e", 8'h00, d)
      wr_reg(BANK_TIMERS, OFF_RELOAD16_HI, 8'ha5);
      rd_reg(BANK_TIMERS, OFF_RELOAD16_HI, d);
      `CHK("reload16 hi", 8'ha5, d)
      $display("test registers done");
      port_a <= 1'b1;
      port_b <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("pin a", 1'b1, pin_a)
      `CHK("pin b", 1'b1, pin_b)
      // timers idle, both outputs low
      for (i = 0; i < 4; i++)
      begin
         wr_reg(BANK_TIMERS, OFF_COMMON_CTRL, 8'h40 | (i[7:0] << 4));
         repeat (3) @(posedge clk);
         `CHK("combine", i >= 2, pin_b)
      end
      $display("test pins done");
      wr_reg(BANK_TIMERS, OFF_CTRL8, 8'h20);
      wr_reg(BANK_TIMERS, OFF_RELOAD8, 8'h05);
      for (i = 0; i < 4; i++)
      begin
         wr_reg(BANK_TIMERS, OFF_CTRL8, 8'h83 | (i[7:0] << 3));
         wait_tog(200, n); // first toggle may come early
         wait_tog(200, n);
         `CHK("period", 6 << i, n)
         wait_tog(200, n);
         `CHK("period", 6 << i, n)
      end
      rd_reg(BANK_TIMERS, OFF_CTRL8, d);
      `CHK("flag on", 8'hbb, d)
      `CHK("irq on", 1'b1, irq_to)
      wr_reg(BANK_TIMERS, OFF_CTRL8, 8'h00);
      rd_reg(BANK_TIMERS, OFF_CTRL8, d);
      `CHK("flag held", 8'h20, d)
      wr_reg(BANK_TIMERS, OFF_CTRL8, 8'h20);
      rd_reg(BANK_TIMERS, OFF_CTRL8, d);
      `CHK("flag clear", 8'h00, d)
      wr_reg(BANK_TIMERS, OFF_CTRL8, 8'hc1);
      wait_tog(200, n);
      wait_tog(100, n);
      `CHK("single", 100, n)
      rd_reg(BANK_TIMERS, OFF_CTRL8, d);
      `CHK("single stop", 8'h61, d)
      `CHK("irq masked", 1'b0, irq_to)
      $display("test counter done");
      wr_reg(BANK_TIMERS, OFF_CTRL8, 8'h20);
      wr_reg(BANK_TIMERS, OFF_RELOAD8, 8'hff);
      wr_reg(BANK_TIMERS, OFF_RELOAD16_LO, 8'hff);
      wr_reg(BANK_TIMERS, OFF_RELOAD16_HI, 8'hff);
      wr_reg(BANK_TIMERS, OFF_COMMON_CTRL, 8'h40);
      wr_reg(BANK_TIMERS, OFF_CTRL16, 8'h80);
      wr_reg(BANK_TIMERS, OFF_CTRL8, 8'h84);
      for (i = 0; i < 4; i++)
      begin
         wr_reg(BANK_TIMERS, OFF_COMMON_CTRL, 8'hc0 | (i[7:0] << 4));
         n_cap = 0;
         i_src.wave(20, 12);
         `CHK("captures", caps[i], n_cap)
         rd_reg(BANK_TIMERS, OFF_CAP8_LO, lo);
         if (i == 0)
            `CHK("no low capture", 8'h00, lo)
      end
      rd_reg(BANK_TIMERS, OFF_CAP8_HI, hi);
      rd_reg(BANK_TIMERS, OFF_CAP16_LO, c16l);
      rd_reg(BANK_TIMERS, OFF_CAP16_HI, c16h);
      `CHK("high minus low", 8'd8, hi - lo)
      `CHK("capture16", {8'h00, hi}, {c16h, c16l})
      wr_reg(BANK_TIMERS, OFF_CAP8_HI, 8'h00);
      wr_reg(BANK_TIMERS, OFF_CAP16_LO, 8'h00);
      rd_reg(BANK_TIMERS, OFF_CAP8_HI, d);
      `CHK("capture8 kept", hi, d)
      rd_reg(BANK_TIMERS, OFF_CAP16_LO, d);
      `CHK("capture16 kept", c16l, d)
      `CHK("demod pin b", 1'b1, pin_b)
      $display("test demod done");
      summarize();
   end
endmodule // dual_counter_timer_tb
